// ==== hw/copro_defines.svh ====
// register map, control and status fields and transfer size codes of the fabric coprocessor
`ifndef COPRO_DEFINES_SVH
`define COPRO_DEFINES_SVH

// ==========================================================================
// register word indices (byte address = 4 * index) and bank numbers (index bits 3:2)
`define COPRO_IDX_CTRL 4'h0
`define COPRO_IDX_STATUS 4'h1
`define COPRO_IDX_RESULT 4'h2
`define COPRO_BANK_STORE 2'h1
`define COPRO_BANK_LOAD 2'h2

// ==========================================================================
// control register fields
`define COPRO_CTRL_W 8
`define COPRO_CTRL_RESET 8'h00
`define COPRO_CTRL_COMB 0
`define COPRO_CTRL_LATE 1
`define COPRO_CTRL_RAISE 2
`define COPRO_CTRL_RAISE_FP 3
`define COPRO_CTRL_KEEP_EXC 4
`define COPRO_CTRL_CLR_EXC 5
`define COPRO_CTRL_CLR_FEX 6

// ==========================================================================
// status register fields
`define COPRO_STS_BUSY 0
`define COPRO_STS_EXC 1
`define COPRO_STS_FEX 2
`define COPRO_STS_FLUSHED 3
`define COPRO_STS_LDIDX 4
`define COPRO_STS_DONECNT 8
`define COPRO_STS_XFER 16

// ==========================================================================
// transfer size codes seen on the link
`define COPRO_SZ_BYTE 3'h4
`define COPRO_SZ_HALF 3'h2
`define COPRO_SZ_WORD 3'h1
`define COPRO_SZ_DOUBLE 3'h3
`define COPRO_SZ_QUAD 3'h7

`endif

// ==== hw/copro_pkg.sv ====
// types shared by the fabric coprocessor and the controller model
package copro_pkg;
  `include "copro_defines.svh"

  // ========================================================================
  // handshake states
  typedef enum logic [2:0] {
    S_IDLE, S_OPS, S_LOAD, S_LATE, S_EXC, S_FIN, S_DRAIN
  } state_e;

  // ========================================================================
  // controller toward coprocessor
  typedef struct packed {
    logic instr_valid;
    logic [31:0] instruction;
    logic [3:0] user_defined_instruction;
    logic decoded_load_flag;
    logic decoded_store_flag;
    logic nonautonomous_flag;
    logic [2:0] transfer_size_code;
    logic ops_valid;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic writeback_permit;
    logic instr_flush;
    logic load_valid;
    logic [127:0] load_data;
    logic [3:0] load_byte_index;
    logic next_instr_ready;
    logic [1:0] fp_exception_mode_bits;
  } ctl_to_copro_s;

  // coprocessor toward controller
  typedef struct packed {
    logic [31:0] copro_result;
    logic copro_result_valid;
    logic [127:0] copro_store_data;
    logic copro_done;
    logic copro_confirm;
    logic copro_exception;
    logic fp_exception_summary;
  } copro_to_ctl_s;

  // ========================================================================
  // whole state of the coprocessor
  typedef struct packed {
    state_e state;
    logic [3:0] user_defined_instruction;
    logic [2:0] xfer;
    logic done_q;
    logic rv_q;
    logic confirm_q;
    logic exception;
    logic fex;
    logic flushed;
    logic [31:0] result;
    logic [`COPRO_CTRL_W-1:0] ctrl;
    logic [3:0][31:0] store_words;
    logic [3:0][31:0] load_words;
    logic [3:0] load_index;
    logic [7:0] done_count;
    logic bus_ack;
    logic [31:0] readdata;
  } copro_state_s;
endpackage

// ==== hw/copro_exec_unit.sv ====
// combinational execution unit selected by the user instruction number
`timescale 1ns/1ps
module copro_exec_unit #(
  parameter int W = 32
) (
  // instruction select and operands
  input wire logic [3:0] i_udi,
  input wire logic [W-1:0] i_op_a,
  input wire logic [W-1:0] i_op_b,
  // result
  output logic [W-1:0] o_result
);
  // ========================================================================
  // operation table; select bit 2 swaps the operands
  logic [W-1:0] a;
  logic [W-1:0] b;

  always_comb begin
    a = i_udi[2] ? i_op_b : i_op_a;
    b = i_udi[2] ? i_op_a : i_op_b;
    unique case (i_udi[1:0])
      2'h0: o_result = a + b;
      2'h1: o_result = a - b;
      2'h2: o_result = a ^ b;
      2'h3: o_result = a & b;
    endcase
  end
endmodule

// ==== hw/copro_fabric_unit.sv ====
// fabric coprocessor answering the processor's instruction handshake
`timescale 1ns/1ps
module copro_fabric_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // avalon-mm register slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // link to the processor's instruction controller
  input wire copro_pkg::ctl_to_copro_s i_ctl,
  output copro_pkg::copro_to_ctl_s o_copro
);
  `include "copro_defines.svh"

  localparam copro_pkg::copro_state_s RST_ST = '{
    state: copro_pkg::S_IDLE,
    ctrl: `COPRO_CTRL_RESET,
    default: '0
  };

  // ========================================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ========================================================================
  // state, execution unit
  copro_pkg::copro_state_s st;
  copro_pkg::copro_state_s next_st;
  logic [31:0] exec_res;
  logic [31:0] rd_word;
  logic [31:0] status;
  logic [31:0] wr_ctrl;
  logic [3:0] idx;
  logic bus_req;
  logic bus_take;
  logic ctrl_wr;
  logic comb;
  logic new_instr;
  logic is_late;
  logic exc_cond;
  logic ops_phase;
  logic load_phase;
  logic done_c;
  logic rv_c;
  logic done_out;
  logic fex_clr;

  copro_exec_unit #(
    .W(32)
  ) u_exec (
    .i_udi(i_ctl.user_defined_instruction),
    .i_op_a(i_ctl.op_a),
    .i_op_b(i_ctl.op_b),
    .o_result(exec_res)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
    return r;
  endfunction

  // ========================================================================
  // register access decode and read side
  assign idx = i_avs_address[5:2];
  assign bus_req = i_avs_read || i_avs_write;
  assign bus_take = i_avs_write && st.bus_ack;
  assign ctrl_wr = bus_take && (idx == `COPRO_IDX_CTRL);
  assign wr_ctrl = merge({24'h0, st.ctrl}, i_avs_writedata, i_avs_byteenable);
  assign fex_clr = ctrl_wr && wr_ctrl[`COPRO_CTRL_CLR_FEX];

  always_comb begin
    status = 32'h0;
    status[`COPRO_STS_BUSY] = (st.state != copro_pkg::S_IDLE);
    status[`COPRO_STS_EXC] = st.exception;
    status[`COPRO_STS_FEX] = st.fex;
    status[`COPRO_STS_FLUSHED] = st.flushed;
    status[`COPRO_STS_LDIDX +: 4] = st.load_index;
    status[`COPRO_STS_DONECNT +: 8] = st.done_count;
    status[`COPRO_STS_XFER +: 3] = st.xfer;
    case (idx)
      `COPRO_IDX_CTRL: rd_word = {24'h0, st.ctrl};
      `COPRO_IDX_STATUS: rd_word = status;
      `COPRO_IDX_RESULT: rd_word = st.result;
      default: begin
        if (idx[3:2] == `COPRO_BANK_STORE) begin
          rd_word = st.store_words[idx[1:0]];
        end else if (idx[3:2] == `COPRO_BANK_LOAD) begin
          rd_word = st.load_words[idx[1:0]];
        end else begin
          rd_word = 32'h0;
        end
      end
    endcase
  end

  // ========================================================================
  // phase decode
  assign comb = st.ctrl[`COPRO_CTRL_COMB];
  assign new_instr = (st.state == copro_pkg::S_IDLE) && i_ctl.instr_valid;
  assign is_late = st.ctrl[`COPRO_CTRL_LATE] && i_ctl.nonautonomous_flag &&
                   !i_ctl.decoded_store_flag && !i_ctl.decoded_load_flag;
  // a held exception turns every late-confirm instruction into one
  assign exc_cond = st.ctrl[`COPRO_CTRL_RAISE] ||
                    st.ctrl[`COPRO_CTRL_RAISE_FP] || st.exception;
  assign ops_phase = (st.state == copro_pkg::S_OPS) ||
                     (new_instr && !i_ctl.decoded_store_flag &&
                      !i_ctl.decoded_load_flag && !is_late);
  assign load_phase = (st.state == copro_pkg::S_LOAD) ||
                      (new_instr && i_ctl.decoded_load_flag);

  // ========================================================================
  // next state
  always_comb begin
    next_st = st;
    done_c = 1'b0;
    rv_c = 1'b0;
    next_st.done_q = 1'b0;
    next_st.rv_q = 1'b0;
    next_st.confirm_q = 1'b0;
    // one wait state per access so read data comes from a flop
    next_st.bus_ack = bus_req && !st.bus_ack;
    if (bus_req && !st.bus_ack) begin
      next_st.readdata = rd_word;
    end
    if (ctrl_wr) begin
      next_st.ctrl = wr_ctrl[`COPRO_CTRL_W-1:0];
      next_st.ctrl[`COPRO_CTRL_CLR_EXC] = 1'b0;
      next_st.ctrl[`COPRO_CTRL_CLR_FEX] = 1'b0;
      if (wr_ctrl[`COPRO_CTRL_CLR_EXC]) begin
        next_st.exception = 1'b0;
      end
      if (wr_ctrl[`COPRO_CTRL_CLR_FEX]) begin
        next_st.fex = 1'b0;
      end
      next_st.flushed = 1'b0;
    end
    for (int k = 0; k < 4; k++) begin
      if (bus_take && idx[3:2] == `COPRO_BANK_STORE &&
          idx[1:0] == 2'(k)) begin
        next_st.store_words[k] = merge(st.store_words[k], i_avs_writedata,
                                       i_avs_byteenable);
      end
    end
    // handshake; hardware sets below win over software clears above
    unique case (st.state)
      copro_pkg::S_IDLE: begin
        if (i_ctl.instr_valid) begin
          next_st.user_defined_instruction = i_ctl.user_defined_instruction;
          next_st.xfer = i_ctl.transfer_size_code;
          if (i_ctl.decoded_store_flag) begin
            if (comb) begin
              done_c = 1'b1;
              rv_c = 1'b1;
            end else begin
              next_st.done_q = 1'b1;
              next_st.rv_q = 1'b1;
              next_st.state = copro_pkg::S_DRAIN;
            end
          end else if (i_ctl.decoded_load_flag) begin
            next_st.state = copro_pkg::S_LOAD;
          end else if (is_late && exc_cond) begin
            next_st.exception = 1'b1;
            if (st.ctrl[`COPRO_CTRL_RAISE_FP]) begin
              next_st.fex = 1'b1;
            end
            next_st.state = copro_pkg::S_EXC;
          end else if (is_late) begin
            next_st.confirm_q = 1'b1;
            next_st.state = copro_pkg::S_LATE;
          end else begin
            next_st.state = copro_pkg::S_OPS;
          end
        end
      end
      copro_pkg::S_OPS, copro_pkg::S_LOAD: begin
      end
      copro_pkg::S_LATE: begin
        if (i_ctl.writeback_permit) begin
          next_st.result = exec_res;
          if (comb) begin
            rv_c = 1'b1;
            done_c = 1'b1;
            next_st.state = copro_pkg::S_IDLE;
          end else begin
            next_st.rv_q = 1'b1;
            next_st.done_q = 1'b1;
            next_st.state = copro_pkg::S_DRAIN;
          end
        end
      end
      copro_pkg::S_EXC: begin
        if (i_ctl.writeback_permit) begin
          next_st.exception = st.ctrl[`COPRO_CTRL_KEEP_EXC];
          if (comb) begin
            done_c = 1'b1;
            next_st.state = copro_pkg::S_IDLE;
          end else begin
            next_st.done_q = 1'b1;
            next_st.state = copro_pkg::S_DRAIN;
          end
        end
      end
      copro_pkg::S_FIN: begin
        next_st.done_q = 1'b1;
        next_st.state = copro_pkg::S_DRAIN;
      end
      copro_pkg::S_DRAIN: begin
        // the controller drops the finished instruction in this cycle
        next_st.state = copro_pkg::S_IDLE;
      end
    endcase
    if (ops_phase && i_ctl.ops_valid) begin
      if (i_ctl.nonautonomous_flag) begin
        next_st.result = exec_res;
        if (comb) begin
          rv_c = 1'b1;
          next_st.done_q = 1'b1;
          next_st.state = copro_pkg::S_DRAIN;
        end else begin
          next_st.rv_q = 1'b1;
          next_st.state = copro_pkg::S_FIN;
        end
      end else if (comb) begin
        done_c = 1'b1;
        next_st.state = copro_pkg::S_IDLE;
      end else begin
        next_st.done_q = 1'b1;
        next_st.state = copro_pkg::S_DRAIN;
      end
    end
    if (load_phase && i_ctl.load_valid) begin
      next_st.load_words = i_ctl.load_data;
      next_st.load_index = i_ctl.load_byte_index;
      if (comb) begin
        done_c = 1'b1;
        next_st.state = copro_pkg::S_IDLE;
      end else begin
        next_st.done_q = 1'b1;
        next_st.state = copro_pkg::S_DRAIN;
      end
    end
    // a flushed instruction ends silently
    if (i_ctl.instr_flush && st.state != copro_pkg::S_IDLE &&
        st.state != copro_pkg::S_DRAIN) begin
      done_c = 1'b0;
      rv_c = 1'b0;
      next_st.done_q = 1'b0;
      next_st.rv_q = 1'b0;
      next_st.flushed = 1'b1;
      next_st.state = copro_pkg::S_IDLE;
      if (st.state == copro_pkg::S_EXC) begin
        next_st.exception = st.ctrl[`COPRO_CTRL_KEEP_EXC] && !new_instr;
        next_st.exception = 1'b0;
      end
    end
    done_out = st.done_q || done_c;
    next_st.done_count = st.done_count + {7'h0, done_out};
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs; same-cycle answers bypass the flops in combinational mode
  assign o_avs_readdata = st.readdata;
  assign o_avs_waitrequest = bus_req && !st.bus_ack;
  assign o_copro.copro_result = rv_c ? exec_res : st.result;
  assign o_copro.copro_result_valid = st.rv_q || rv_c;
  assign o_copro.copro_store_data = st.store_words;
  assign o_copro.copro_done = done_out;
  assign o_copro.copro_confirm = st.confirm_q;
  assign o_copro.copro_exception = st.exception;
  assign o_copro.fp_exception_summary = st.fex;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  AST_DONE_PULSE: assert property (st.done_q |=> !st.done_q)
    else $error("registered completion lasted more than one cycle");
  AST_LATE_CONFIRM: assert property (
    new_instr && is_late && !exc_cond |=>
      o_copro.copro_confirm && !o_copro.copro_exception)
    else $error("late-confirm instruction was not confirmed");
  AST_LATE_RESULT: assert property (
    st.state == copro_pkg::S_LATE && i_ctl.writeback_permit && !comb &&
    !i_ctl.instr_flush |=> o_copro.copro_result_valid && o_copro.copro_done)
    else $error("late-confirm result missing after permit");
  AST_EARLY_REG: assert property (
    ops_phase && i_ctl.ops_valid && i_ctl.nonautonomous_flag && !comb &&
    !i_ctl.instr_flush |=>
      o_copro.copro_result_valid && !o_copro.copro_done ##1
      o_copro.copro_done)
    else $error("registered early-confirm timing broken");
  AST_EARLY_COMB: assert property (
    ops_phase && i_ctl.ops_valid && i_ctl.nonautonomous_flag && comb &&
    !i_ctl.instr_flush |-> o_copro.copro_result_valid ##1 o_copro.copro_done)
    else $error("combinational early-confirm timing broken");
  AST_STORE_REG: assert property (
    new_instr && i_ctl.decoded_store_flag && !comb |=>
      o_copro.copro_done && o_copro.copro_result_valid ##1
      !o_copro.copro_done)
    else $error("registered store answer not on next clock");
  AST_STORE_COMB: assert property (
    new_instr && i_ctl.decoded_store_flag && comb |->
      o_copro.copro_done && o_copro.copro_result_valid)
    else $error("combinational store answer not in same clock");
  AST_LOAD_COMB: assert property (
    load_phase && i_ctl.load_valid && comb && !i_ctl.instr_flush |->
      o_copro.copro_done)
    else $error("combinational load not completed in same clock");
  AST_EXC_RAISE: assert property (
    new_instr && is_late && exc_cond |=>
      o_copro.copro_exception && !o_copro.copro_confirm)
    else $error("exception not raised in place of confirm");
  AST_EXC_ACK: assert property (
    st.state == copro_pkg::S_EXC && i_ctl.writeback_permit && !comb &&
    !i_ctl.instr_flush |=> o_copro.copro_done)
    else $error("taken exception was not completed");
  AST_EXC_FLUSH: assert property (
    st.state == copro_pkg::S_EXC && i_ctl.instr_flush |->
      !o_copro.copro_done ##1 !o_copro.copro_exception)
    else $error("flushed exception still completed or held");
  AST_FEX_STICKY: assert property (
    o_copro.fp_exception_summary && !fex_clr |=>
      o_copro.fp_exception_summary)
    else $error("floating summary flag dropped without software clear");
endmodule

// ==== verif/copro_ctl_model.sv ====
// controller-side model that drives the coprocessor instruction link
`timescale 1ns/1ps
module copro_ctl_model (
  // clock
  input wire logic i_clk,
  // link
  input wire copro_pkg::copro_to_ctl_s i_copro,
  output copro_pkg::ctl_to_copro_s o_ctl
);
  // ==========================================================================
  // link drive
  copro_pkg::ctl_to_copro_s c;
  assign o_ctl = c;
  initial begin
    c = '0;
    c.fp_exception_mode_bits = 2'h3;
  end

  // ==========================================================================
  // one instruction; kind 0 store, 1 load, 2 non-autonomous, 3 autonomous
  // keep leaves the valid up so the next call follows back to back
  task automatic send(input int kind, input logic [2:0] sz,
      input logic [3:0] user_defined_instruction, input logic [31:0] a, input logic [31:0] b,
      input logic [127:0] ld, input logic [3:0] idx, input logic late,
      input logic fl, input logic keep, output logic [31:0] res,
      output int lat, output int rvl, output logic exc);
    logic wb;
    logic fsh;
    logic sent;
    int fi;
    res = '0;
    lat = -1;
    rvl = -1;
    exc = 1'b0;
    sent = 1'b0;
    fi = 99;
    c.instr_valid <= 1'b1;
    c.user_defined_instruction <= user_defined_instruction;
    c.decoded_store_flag <= (kind == 0);
    c.decoded_load_flag <= (kind == 1);
    c.nonautonomous_flag <= (kind == 0 || kind == 2);
    c.transfer_size_code <= sz;
    for (int i = 0; i < 40 && lat < 0; i++) begin
      @(posedge i_clk);
      if (i_copro.copro_result_valid) begin
        res = i_copro.copro_result;
        rvl = i;
      end
      exc |= i_copro.copro_exception;
      // a held exception counts against every late-confirm instruction
      wb = !sent && ((i == 0 && kind >= 2 && !late) || (late && !fl &&
        (i_copro.copro_confirm || i_copro.copro_exception)));
      fsh = !sent && fl && i_copro.copro_exception;
      sent |= wb | fsh;
      if (fsh) fi = i;
      c.writeback_permit <= wb;
      c.instr_flush <= fsh;
      if (i_copro.copro_done || i == fi + 3) begin
        lat = i;
        // released data must not look valid, so it is turned over
        if (!keep) c.instr_valid <= 1'b0;
        c.next_instr_ready <= keep;
        c.ops_valid <= 1'b0;
        c.load_valid <= 1'b0;
        c.op_a <= ~a;
        c.op_b <= ~b;
        c.load_data <= ~ld;
      end else if (i == fi + 1) begin
        // a flushed instruction is withdrawn at once, nothing completes it
        c.instr_valid <= 1'b0;
      end else if (i == 0) begin
        c.next_instr_ready <= 1'b0;
        c.ops_valid <= (kind >= 2);
        c.op_a <= a;
        c.op_b <= b;
        c.load_valid <= (kind == 1);
        c.load_data <= ld;
        c.load_byte_index <= idx;
      end
    end
  endtask
endmodule

// ==== verif/copro_fabric_unit_test.sv ====
// self-checking bench of the fabric coprocessor against a controller model
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] %s expected %0h seen %0h", nm, (exp), (got)); \
  end \
end
module copro_fabric_unit_test;
  // ==========================================================================
  // signals
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [5:0] i_avs_address = 6'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  copro_pkg::ctl_to_copro_s i_ctl;
  copro_pkg::copro_to_ctl_s o_copro;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] rv;
  logic [31:0] res;
  int lat;
  int rvl;
  logic exc;
  logic [127:0] ldx = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic [3:0] idx = 4'h0;

  always #50 i_clk = ~i_clk;

  copro_fabric_unit dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_ctl(i_ctl),
    .o_copro(o_copro));
  copro_ctl_model ctl_u (.i_clk(i_clk), .i_copro(o_copro), .o_ctl(i_ctl));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] ex(input logic [3:0] u);
    logic [31:0] x;
    logic [31:0] y;
    x = u[2] ? 32'h00001234 : 32'h90000F00 + 32'(u);
    y = u[2] ? 32'h90000F00 + 32'(u) : 32'h00001234;
    case (u[1:0])
      2'h0: ex = x + y;
      2'h1: ex = x - y;
      2'h2: ex = x ^ y;
      default: ex = x & y;
    endcase
  endfunction

  task automatic go(input int kind, input logic [2:0] sz, input logic [3:0] u,
      input logic late, input logic fl, input logic keep);
    ctl_u.send(kind, sz, u, 32'h90000F00 + 32'(u), 32'h00001234, ldx, idx,
      late, fl, keep, res, lat, rvl, exc);
  endtask

  task automatic bus(input logic wr, input logic [5:0] ad,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= ad;
    i_avs_writedata <= wd;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
    rv = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic do_reset;
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    `CHECK("link outputs", '0, o_copro)
    bus(0, 6'h00, 32'h0);
    `CHECK("control", 32'h0, rv)
    bus(1, 6'h3C, 32'hFFFFFFFF);
    bus(0, 6'h3C, 32'h0);
    `CHECK("unmapped", 32'h0, rv)
    bus(0, 6'h04, 32'h0);
    `CHECK("status", 32'h0, rv)
  endtask

  task automatic t_store;
    logic [2:0] sz [5] = '{3'h4, 3'h2, 3'h1, 3'h3, 3'h7};
    for (int k = 0; k < 4; k++) bus(1, 6'h10 + 6'(4 * k), 32'hC0DE0000 + k);
    foreach (sz[j]) begin
      go(0, sz[j], 4'h0, 0, 0, 0);
      bus(0, 6'h04, 32'h0);
      `CHECK("size", sz[j], rv[18:16])
      `CHECK("done count", 8'(j + 1), rv[15:8])
    end
    for (int m = 0; m < 2; m++) begin
      bus(1, 6'h00, 32'(m));
      for (int n = 0; n < 2; n++) begin
        go(0, 3'h7, 4'h0, 0, 0, n == 0);
        `CHECK("store lat", 1 - m, lat)
        `CHECK("store valid", lat, rvl)
        `CHECK("store data", 128'hC0DE0003C0DE0002C0DE0001C0DE0000,
          o_copro.copro_store_data)
      end
    end
  endtask

  task automatic t_load;
    for (int m = 0; m < 2; m++) begin
      bus(1, 6'h00, 32'(m));
      idx = 4'h3 + 4'(m);
      for (int n = 0; n < 2; n++) begin
        ldx = ldx + 1;
        go(1, 3'h7, 4'h0, 0, 0, n == 0);
        `CHECK("load lat", 2 - m, lat)
      end
      for (int k = 0; k < 4; k++) begin
        bus(0, 6'h20 + 6'(4 * k), 32'h0);
        `CHECK("load word", ldx[32 * k +: 32], rv)
      end
      bus(0, 6'h04, 32'h0);
      `CHECK("byte index", idx, rv[7:4])
    end
  endtask

  task automatic t_early;
    for (int m = 0; m < 2; m++) begin
      bus(1, 6'h00, 32'(m));
      for (int u = 0; u < 8; u++) begin
        go(2, 3'h0, 4'(u), 0, 0, u < 7);
        `CHECK("result", ex(4'(u)), res)
        `CHECK("early lat", 3 - m, lat)
        `CHECK("early valid", lat - 1, rvl)
      end
      bus(0, 6'h08, 32'h0);
      `CHECK("last result", ex(4'h7), rv)
      go(3, 3'h0, 4'h2, 0, 0, 0);
      `CHECK("auton lat", 2 - m, lat)
    end
  endtask

  task automatic t_late;
    for (int m = 0; m < 2; m++) begin
      bus(1, 6'h00, 32'h2 | m);
      go(2, 3'h0, 4'h5, 1, 0, 0);
      `CHECK("late result", ex(4'h5), res)
      `CHECK("late lat", 3 - m, lat)
      `CHECK("late valid", lat, rvl)
      `CHECK("late exc", 1'b0, exc)
    end
  endtask

  task automatic t_exc;
    bus(1, 6'h00, 32'h16);
    go(2, 3'h0, 4'h1, 1, 0, 0);
    `CHECK("exc seen", 1'b1, exc)
    `CHECK("exc lat", 3, lat)
    repeat (2) @(posedge i_clk);
    `CHECK("exc held", 1'b1, o_copro.copro_exception)
    bus(1, 6'h00, 32'h12);
    go(2, 3'h0, 4'h1, 1, 0, 0);
    `CHECK("held exc", 1'b1, exc)
    bus(1, 6'h00, 32'h22);
    repeat (2) @(posedge i_clk);
    `CHECK("exc cleared", 1'b0, o_copro.copro_exception)
    go(2, 3'h0, 4'h3, 1, 0, 0);
    `CHECK("clean exc", 1'b0, exc)
    `CHECK("clean result", ex(4'h3), res)
  endtask

  task automatic t_flush;
    bus(1, 6'h00, 32'h06);
    go(2, 3'h0, 4'h1, 1, 1, 0);
    `CHECK("flush exc", 1'b1, exc)
    `CHECK("no done", 4, lat)
    `CHECK("exc dropped", 1'b0, o_copro.copro_exception)
    bus(0, 6'h04, 32'h0);
    `CHECK("flushed", 1'b1, rv[3])
  endtask

  task automatic t_fp;
    bus(1, 6'h00, 32'h0A);
    go(2, 3'h0, 4'h1, 1, 0, 0);
    `CHECK("fp exc", 1'b1, exc)
    bus(1, 6'h00, 32'h22);
    repeat (2) @(posedge i_clk);
    `CHECK("fex kept", 1'b1, o_copro.fp_exception_summary)
    bus(1, 6'h00, 32'h40);
    repeat (2) @(posedge i_clk);
    `CHECK("fex clear", 1'b0, o_copro.fp_exception_summary)
  endtask

  // ==========================================================================
  // run and verdict
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    do_reset;
    t_reset;
    t_store;
    t_load;
    t_early;
    t_late;
    t_exc;
    t_flush;
    t_fp;
    // leave exception and summary flag held, then reset in mid-run
    bus(1, 6'h00, 32'h1A);
    go(2, 3'h0, 4'h1, 1, 0, 0);
    do_reset;
    t_reset;
    wrap_up;
  end

  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end
endmodule
